// ---- src/rbc_board.sv ----
// Board end: four trigger/busy channels, counters, display and bus decode
// How it works
// (R1) Answer only when address 23:8 matches base
// (R2) Base address from four rotary nibbles
// (R3) Twelve lamps mirror one selected channel
// (R4) Two selector switches choose the shown channel
// (R5) Lamps: status 8..11 then control 0..7
// (R6) Control 0xEC: enabled, latched, test source
// (R7) Test write sets busy, release write clears
// (R8) Busy changes on the access itself
// (R9) Event counter counts generated busy pulses
// (R10) Host loads offset; overflow raises time-out
// (R11) Host event task ends with busy release
// (R12) Host follows the fixed initialisation order
// (R13) Shared busy wired-OR, selectable on output
// (R14) Control bit 1 makes busy follow trigger
// (R15) Host issues system reset before use
// (R16) Reset sets control bits 0..7 to one
// (R17) Release at 0x58.., test at 0x50..
// (R18) Bits 3:2 select trigger source
// (R19) Low address byte selects the register
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "rbc_defines.svh"
module rbc_board (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Host side
	rbc_vme_if.board vme,
	// Trigger inputs
	input wire logic [3:0] trig_panel_n,
	input wire logic [3:0] trig_diff,
	input wire logic fast_clear_n,
	input wire logic slow_clk,
	// Switches
	input wire logic [15:0] base_sw,
	input wire logic disp_top_left,
	input wire logic disp_bot_left,
	// Front panel outputs
	output logic [3:0] busy_out,
	output logic [11:0] led
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int SW = 32;
	logic [SW-1:0] pins_w;
	logic [SW-1:0] sync1_r; // Read only by sync2_r
	logic [SW-1:0] sync2_r;
	logic [3:0] panel_s;
	logic [3:0] diff_s;
	logic [3:0] line_s;
	logic slow_s;
	logic fc_s;
	logic [15:0] base_s;
	logic [1:0] disp_s;
	logic rst;

	assign pins_w = {trig_panel_n, trig_diff, vme.busy_line, slow_clk,
		fast_clear_n, base_sw, disp_bot_left, disp_top_left};
	assign {panel_s, diff_s, line_s, slow_s, fc_s, base_s, disp_s} = sync2_r;
	// Board resets on its own reset or on the system reset line
	assign rst = !aresetn || !vme.sysreset_n;

	// Two flops on every outside level
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pins_w;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------
	// Slow clock tick
	// ----------------------------------------
	logic slow_prev_r;
	logic tick;
	assign tick = slow_s && !slow_prev_r;

	// Rising edge of the 100 us clock paces the dead-time counters
	always_ff @(posedge aclk)
	begin
		if (rst)
			slow_prev_r <= 1'b0;
		else
			slow_prev_r <= slow_s;
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic done_r; // Access answered, waiting for strobe to drop
	logic hit;
	logic acc_wr;
	logic [7:0] off;

	// Word compare, byte lane bit ignored
	function automatic logic is_at(input logic [7:0] o, input logic [7:0] a);
		return o[7:1] == a[7:1];
	endfunction

	assign hit = vme.strb && !done_r && (vme.addr[23:8] == base_s); // [R1] [R2]
	assign acc_wr = hit && vme.wr;
	assign off = vme.addr[7:0]; // [R19]

	// One answer per strobe
	always_ff @(posedge aclk)
	begin
		if (rst)
			done_r <= 1'b0;
		else if (hit)
			done_r <= 1'b1;
		else if (!vme.strb)
			done_r <= 1'b0;
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	logic [11:0] csr_view [4];
	logic [31:0] evt_view [4];
	logic [15:0] dt_view [4];
	wire [3:0] eflag_w;
	wire [3:0] tflag_w;
	wire [3:0] busy_out_w;
	wire [3:0] bus_oe_w;
	logic [7:0] imask_r;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_ch
			logic [7:0] csr_r;
			logic busy_r;
			logic busy_nxt;
			logic trig_prev_r;
			logic busy_out_r;
			logic bus_oe_r;
			logic eirq_r;
			logic tirq_r;
			logic [31:0] evt_r;
			logic [15:0] dt_r;
			logic [15:0] dto_r;
			logic trig;
			logic test_w;
			logic clr_w;
			logic en;
			logic trig_rise;
			logic busy_rise;
			logic ovf;
			logic iclr;
			logic [7:0] o_csr;
			logic [7:0] o_evt;
			logic [7:0] o_dt;
			rbc_pkg::rbc_src_t src;

			assign o_csr = 8'(`RBC_OFF_CSR + 2 * gi);
			assign o_evt = 8'(`RBC_OFF_EVT + 4 * gi);
			assign o_dt = 8'(`RBC_OFF_DT + 2 * gi);
			assign test_w = acc_wr && is_at(off, 8'(`RBC_OFF_TEST + 2 * gi)); // [R17]
			assign clr_w = acc_wr && is_at(off, 8'(`RBC_OFF_CLR + 2 * gi)); // [R17]
			assign src = rbc_pkg::rbc_src_t'(csr_r[`RBC_B_SRC_HI:`RBC_B_SRC_LO]);
			assign en = !csr_r[`RBC_B_DIS]; // [R6]
			assign trig_rise = en && trig && !trig_prev_r;
			assign busy_rise = busy_nxt && !busy_r;
			assign ovf = busy_r && tick && (dt_r == `RBC_DT_LAST);
			assign iclr = acc_wr && is_at(off, `RBC_OFF_IFLAG);

			// Source select; panel input is active low
			always_comb
			begin
				unique case (src) // [R18]
					rbc_pkg::src_panel: trig = !panel_s[gi];
					rbc_pkg::src_diff_inv: trig = !diff_s[gi];
					rbc_pkg::src_diff: trig = diff_s[gi];
					rbc_pkg::src_test: trig = test_w;
				endcase
			end

			// Busy: free-running copy or latch; the set wins over release
			always_comb
			begin
				if (csr_r[`RBC_B_FREE])
					busy_nxt = en && trig; // [R14]
				else
					busy_nxt = test_w || trig_rise || (busy_r && !clr_w); // [R7]
			end

			// Control bits, all ones after reset
			always_ff @(posedge aclk)
			begin
				if (rst)
					csr_r <= `RBC_CSR_RESET; // [R16]
				else if (acc_wr && is_at(off, o_csr))
					csr_r <= vme.wdata[7:0]; // [R6]
			end

			// Busy state, line drive and local-mode busy_out move on the access edge itself
			always_ff @(posedge aclk)
			begin
				if (rst)
				begin
					busy_r <= 1'b0;
					trig_prev_r <= 1'b0;
					busy_out_r <= 1'b0;
					bus_oe_r <= 1'b0;
				end
				else
				begin
					busy_r <= busy_nxt; // [R8]
					trig_prev_r <= trig;
					// Output shows local or system-wide busy
					busy_out_r <= csr_r[`RBC_B_OSEL] ? line_s[gi] : busy_nxt; // [R13]
					bus_oe_r <= busy_nxt; // [R13]
				end
			end

			// Event counter: host write, fast clear, then counting
			always_ff @(posedge aclk)
			begin
				if (rst)
					evt_r <= '0;
				else if (acc_wr && is_at(off, o_evt))
					evt_r[31:16] <= vme.wdata;
				else if (acc_wr && is_at(off, o_evt + `RBC_OFF_EVT_LO))
					evt_r[15:0] <= vme.wdata;
				else if (!csr_r[`RBC_B_FCDIS] && !fc_s)
					evt_r <= '0;
				else if (csr_r[`RBC_B_CSEL] ? busy_rise : trig_rise)
					evt_r <= evt_r + 32'h1; // [R9]
			end

			// Dead time: write sets offset; busy start reloads it
			always_ff @(posedge aclk)
			begin
				if (rst)
				begin
					dt_r <= '0;
					dto_r <= '0;
				end
				else if (acc_wr && is_at(off, o_dt))
				begin
					dt_r <= vme.wdata;
					dto_r <= vme.wdata;
				end
				else if (busy_rise)
					dt_r <= dto_r;
				else if (busy_r && tick)
					dt_r <= dt_r + 16'h1;
			end

			// Sticky interrupt flags, cleared by a one; set wins
			always_ff @(posedge aclk)
			begin
				if (rst)
				begin
					eirq_r <= 1'b0;
					tirq_r <= 1'b0;
				end
				else
				begin
					eirq_r <= busy_rise || (eirq_r && !(iclr && vme.wdata[gi]));
					tirq_r <= ovf || (tirq_r && // [R10]
						!(iclr && vme.wdata[gi + `RBC_TOUT_FLAG_LO]));
				end
			end

			assign csr_view[gi] = {eirq_r || tirq_r, line_s[gi], busy_r, trig,
				csr_r};
			assign evt_view[gi] = evt_r;
			assign dt_view[gi] = dt_r;
			assign eflag_w[gi] = eirq_r;
			assign tflag_w[gi] = tirq_r;
			assign busy_out_w[gi] = busy_out_r;
			assign bus_oe_w[gi] = bus_oe_r;
		end
	endgenerate

	// ----------------------------------------
	// Interrupt mask and read data
	// ----------------------------------------
	logic [15:0] rd_nxt;
	logic [15:0] rdata_r;
	logic ack_r;
	logic irq_r;
	logic [11:0] led_r;

	// Interrupt mask, all off after reset
	always_ff @(posedge aclk)
	begin
		if (rst)
			imask_r <= '0;
		else if (acc_wr && is_at(off, `RBC_OFF_IMASK))
			imask_r <= vme.wdata[7:0];
	end

	// Read mux; unmapped words read zero
	always_comb
	begin
		rd_nxt = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (is_at(off, 8'(`RBC_OFF_CSR + 2 * i)))
				rd_nxt = {4'h0, csr_view[i]};
			if (is_at(off, 8'(`RBC_OFF_EVT + 4 * i)))
				rd_nxt = evt_view[i][31:16];
			if (is_at(off, 8'(`RBC_OFF_EVT + 4 * i + 2)))
				rd_nxt = evt_view[i][15:0];
			if (is_at(off, 8'(`RBC_OFF_DT + 2 * i)))
				rd_nxt = dt_view[i];
		end
		if (is_at(off, `RBC_OFF_IFLAG))
			rd_nxt = {8'h0, tflag_w, eflag_w};
		if (is_at(off, `RBC_OFF_IMASK))
			rd_nxt = {8'h0, imask_r};
	end

	// Answer one cycle after the strobe is seen
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			ack_r <= 1'b0;
			rdata_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			ack_r <= hit;
			if (hit && !vme.wr)
				rdata_r <= rd_nxt;
			irq_r <= |({tflag_w, eflag_w} & imask_r);
		end
	end

	// Lamp 0 is the top lamp: status bits first, then control
	always_ff @(posedge aclk)
	begin
		if (rst)
			led_r <= '0;
		else
			led_r <= {csr_view[disp_s][7:0], csr_view[disp_s][11:8]}; // [R3] [R4] [R5]
	end

	assign vme.ack = ack_r;
	assign vme.rdata = rdata_r;
	assign vme.irq = irq_r;
	assign vme.busy_drv_o = bus_oe_w;
	assign vme.busy_drv_oe = bus_oe_w;
	assign busy_out = busy_out_w;
	assign led = led_r;

endmodule

// ---- src/rbc_defines.svh ----
// Offsets, field positions and reset values of the read-out busy controller
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH

// ----------------------------------------
// Board register map (low address byte)
// ----------------------------------------
`define RBC_OFF_CSR 8'h00
`define RBC_OFF_EVT 8'h10
`define RBC_OFF_DT 8'h20
`define RBC_OFF_IFLAG 8'h40
`define RBC_OFF_IMASK 8'h42
`define RBC_OFF_TEST 8'h50
`define RBC_OFF_CLR 8'h58
`define RBC_OFF_EVT_LO 8'h02

// ----------------------------------------
// Channel control/status fields
// ----------------------------------------
`define RBC_CSR_RESET 8'hff
`define RBC_B_DIS 0
`define RBC_B_FREE 1
`define RBC_B_SRC_LO 2
`define RBC_B_SRC_HI 3
`define RBC_B_OSEL 4
`define RBC_B_CSEL 5
`define RBC_B_FCDIS 6
`define RBC_TOUT_FLAG_LO 4
`define RBC_DT_LAST 16'hffff
`define RBC_DT_OFFSET_10MS 16'hff9c
`define RBC_CSR_TEST_LATCHED 8'hec

// ----------------------------------------
// Host register map (AXI4-Lite byte offsets)
// ----------------------------------------
`define RBC_H_ADDR 8'h00
`define RBC_H_WDATA 8'h04
`define RBC_H_CTRL 8'h08
`define RBC_H_STAT 8'h0c
`define RBC_H_RDATA 8'h10
`define RBC_H_ISTAT 8'h14
`define RBC_H_IMASK 8'h18
`define RBC_H_GO 0
`define RBC_H_DIR 1
`define RBC_H_SYSRES 2

`endif

// ---- src/rbc_host.sv ----
// Host end: AXI4-Lite registers that run single bus cycles to the board
`timescale 1ns/100ps
`include "rbc_defines.svh"
module rbc_host #(
	parameter int TIMEOUT = 255
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Interrupt
	output logic irq,
	// Board side
	rbc_vme_if.host vme
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [23:0] addr_r;
	logic [15:0] wd_r;
	logic dir_r;
	logic sysres_r; // Board held in reset while set
	logic [15:0] rd_r;
	logic [2:0] istat_r;
	logic [2:0] imask_r;
	logic [7:0] awa_r;
	logic [31:0] wda_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdout_r;
	logic irq_r;
	logic do_wr;
	logic go;

	// Both halves of a write held and the response slot free
	assign do_wr = !awready_r && !wready_r && !bvalid_r;
	assign go = do_wr && (awa_r == `RBC_H_CTRL) && wda_r[`RBC_H_GO];

	// ----------------------------------------
	// AXI write channel
	// ----------------------------------------
	// Address and data taken in either order, response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			awa_r <= '0;
			wda_r <= '0;
		end
		else
		begin
			if (s_awvalid && awready_r)
			begin
				awa_r <= s_awaddr;
				awready_r <= 1'b0;
			end
			if (s_wvalid && wready_r)
			begin
				wda_r <= s_wdata;
				wready_r <= 1'b0;
			end
			if (do_wr)
				bvalid_r <= 1'b1;
			else if (bvalid_r && s_bready)
			begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Register stores; byte strobes ignored, whole words only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			addr_r <= '0;
			wd_r <= '0;
			dir_r <= 1'b0;
			sysres_r <= 1'b1; // [R15]
			imask_r <= '0;
		end
		else if (do_wr)
		begin
			if (awa_r == `RBC_H_ADDR)
				addr_r <= wda_r[23:0];
			if (awa_r == `RBC_H_WDATA)
				wd_r <= wda_r[15:0];
			if (awa_r == `RBC_H_CTRL)
			begin
				dir_r <= wda_r[`RBC_H_DIR];
				sysres_r <= wda_r[`RBC_H_SYSRES]; // [R15]
			end
			if (awa_r == `RBC_H_IMASK)
				imask_r <= wda_r[2:0];
		end
	end

	// ----------------------------------------
	// Board bus cycle
	// ----------------------------------------
	rbc_pkg::rbc_hstate_t st_r;
	logic strb_r;
	logic [8:0] cnt_r;
	logic ev_done;
	logic ev_tout;
	logic irq_prev_r;

	assign ev_done = (st_r == rbc_pkg::hst_strobe) && vme.ack;
	assign ev_tout = (st_r == rbc_pkg::hst_strobe) && !vme.ack &&
		(cnt_r == 9'(TIMEOUT));

	// Strobe held until the board answers or the wait runs out
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= rbc_pkg::hst_idle;
			strb_r <= 1'b0;
			cnt_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			unique case (st_r)
				rbc_pkg::hst_idle:
				begin
					cnt_r <= '0;
					if (go && !sysres_r)
					begin
						st_r <= rbc_pkg::hst_strobe;
						strb_r <= 1'b1;
					end
				end
				rbc_pkg::hst_strobe:
				begin
					cnt_r <= cnt_r + 9'h1;
					if (ev_done || ev_tout)
					begin
						st_r <= rbc_pkg::hst_idle;
						strb_r <= 1'b0;
					end
					if (ev_done && !dir_r)
						rd_r <= vme.rdata;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Bit 0 cycle done, bit 1 no answer, bit 2 board interrupt; set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			istat_r <= '0;
			irq_prev_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			irq_prev_r <= vme.irq;
			istat_r <= {vme.irq && !irq_prev_r, ev_tout, ev_done} |
				(istat_r & ~((do_wr && awa_r == `RBC_H_ISTAT) ?
				wda_r[2:0] : 3'h0));
			irq_r <= |(istat_r & imask_r);
		end
	end

	// ----------------------------------------
	// AXI read channel
	// ----------------------------------------
	// Answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdout_r <= '0;
		end
		else if (s_arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			unique case (s_araddr)
				`RBC_H_ADDR: rdout_r <= {8'h0, addr_r};
				`RBC_H_WDATA: rdout_r <= {16'h0, wd_r};
				`RBC_H_CTRL: rdout_r <= {29'h0, sysres_r, dir_r, 1'b0};
				`RBC_H_STAT: rdout_r <= {31'h0, st_r == rbc_pkg::hst_strobe};
				`RBC_H_RDATA: rdout_r <= {16'h0, rd_r};
				`RBC_H_ISTAT: rdout_r <= {29'h0, istat_r};
				`RBC_H_IMASK: rdout_r <= {29'h0, imask_r};
				default: rdout_r <= '0;
			endcase
		end
		else if (rvalid_r && s_rready)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign s_awready = awready_r;
	assign s_wready = wready_r;
	assign s_bresp = 2'h0;
	assign s_bvalid = bvalid_r;
	assign s_arready = arready_r;
	assign s_rdata = rdout_r;
	assign s_rresp = 2'h0;
	assign s_rvalid = rvalid_r;
	assign irq = irq_r;
	assign vme.sysreset_n = !sysres_r;
	assign vme.strb = strb_r;
	assign vme.wr = dir_r;
	assign vme.addr = addr_r;
	assign vme.wdata = wd_r;

endmodule

// ---- src/rbc_pkg.sv ----
// Types shared by both ends of the read-out busy controller
package rbc_pkg;

	// Trigger source select, in field order
	typedef enum logic [1:0] {
		src_panel,
		src_diff_inv,
		src_diff,
		src_test
	} rbc_src_t;

	// Host bus-cycle state
	typedef enum logic {
		hst_idle,
		hst_strobe
	} rbc_hstate_t;

endpackage

// ---- src/rbc_vme_if.sv ----
// Bus, reset and shared busy lines between host and board
`timescale 1ns/100ps
interface rbc_vme_if;
	// System reset, active low
	logic sysreset_n;
	// Access request held by the host
	logic strb;
	logic wr;
	logic [23:0] addr;
	logic [15:0] wdata;
	// Answer from the board
	logic ack;
	logic [15:0] rdata;
	logic irq;
	// Shared busy lines, one per channel
	logic [3:0] busy_drv_o;
	logic [3:0] busy_drv_oe;
	logic [3:0] busy_ext;
	logic [3:0] busy_line;

	// Wired-OR: any driving board or any outside board holds the line
	assign busy_line = (busy_drv_oe & busy_drv_o) | busy_ext;

	modport board (
		input sysreset_n, strb, wr, addr, wdata, busy_line,
		output ack, rdata, irq, busy_drv_o, busy_drv_oe
	);
	modport host (
		output sysreset_n, strb, wr, addr, wdata,
		input ack, rdata, irq
	);
endinterface

// ---- tb/rbc_chk.sv ----
// Concurrent checks on the bus and busy lines between host and board
`timescale 1ns/100ps
module rbc_chk #(
	parameter logic [15:0] BASE = 16'h0000
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus request and answer
	input wire logic sysreset_n,
	input wire logic strb,
	input wire logic wr,
	input wire logic [23:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata,
	input wire logic irq,
	// Shared busy lines
	input wire logic [3:0] busy_drv_o,
	input wire logic [3:0] busy_drv_oe,
	input wire logic [3:0] busy_ext,
	input wire logic [3:0] busy_line
);
	// Strobe aimed at this board
	logic hit;
	// Channel picked by a test or release address
	logic [1:0] ch;

	assign hit = strb && addr[23:8] == BASE;
	assign ch = addr[2:1];

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_ACK_TAKE: assert property (hit && !ack && sysreset_n |=> ack)
		else $error("matching strobe not answered");
	AST_ACK_CAUSE: assert property ($rose(ack) |-> $past(hit))
		else $error("answer without matching strobe");
	AST_NO_MATCH: assert property (strb && !hit |=> !ack)
		else $error("answer to a foreign address");
	AST_ACK_ONE: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	AST_TEST_SET: assert property (ack && wr && addr[7:3] == 5'h0a
		|-> busy_drv_o[ch])
		else $error("test write left busy low");
	AST_CLR_REL: assert property (ack && wr && addr[7:3] == 5'h0b
		|-> !busy_drv_o[ch])
		else $error("release write left busy high");
	AST_DRIVE: assert property (ack && wr && addr[7:3] == 5'h0a
		|-> busy_line[ch])
		else $error("local busy missing from shared line");
	AST_RESET_QUIET: assert property (!sysreset_n [*2]
		|-> !ack && busy_drv_o == 4'h0 && !irq)
		else $error("board active in system reset");
endmodule

// ---- tb/test_readout_busy_controller.sv ----
// Self-checking bench: host and board joined over the bus interface
`timescale 1ns/100ps
`include "rbc_defines.svh"
`define CHK(nm, ex, ac) \
	begin \
		checks++; \
		if ((ac) !== (ex)) \
		begin \
			err_count++; \
			$display("mismatch %s expected %h seen %h", nm, ex, ac); \
		end \
	end
module test_readout_busy_controller;
	// Nibbles all differ so a swapped switch shows up
	localparam logic [15:0] BASE = 16'ha5c3;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd_word;
	logic [3:0] s_wstrb, trig_panel_n, trig_diff, busy_out;
	logic fast_clear_n, slow_clk, disp_top_left, disp_bot_left;
	logic [11:0] led;
	logic [15:0] tgt;
	logic [7:0] exp_csr [4] = '{8'hac, 8'he0, 8'hf0, 8'hec};
	int err_count = 0;
	int checks = 0;

	// ----------------------------------------
	// Clock, design and checker
	// ----------------------------------------
	always #10 aclk = ~aclk;
	rbc_vme_if rbc_vme_if_i ();
	rbc_host #(.TIMEOUT(8)) rbc_host_i (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .irq(irq),
		.vme(rbc_vme_if_i));
	rbc_board rbc_board_i (.aclk(aclk), .aresetn(aresetn), .vme(rbc_vme_if_i),
		.trig_panel_n(trig_panel_n), .trig_diff(trig_diff),
		.fast_clear_n(fast_clear_n), .slow_clk(slow_clk), .base_sw(BASE),
		.disp_top_left(disp_top_left), .disp_bot_left(disp_bot_left),
		.busy_out(busy_out), .led(led));
	rbc_chk #(.BASE(BASE)) rbc_chk_i (.aclk(aclk), .aresetn(aresetn),
		.sysreset_n(rbc_vme_if_i.sysreset_n), .strb(rbc_vme_if_i.strb),
		.wr(rbc_vme_if_i.wr), .addr(rbc_vme_if_i.addr),
		.wdata(rbc_vme_if_i.wdata), .ack(rbc_vme_if_i.ack),
		.rdata(rbc_vme_if_i.rdata), .irq(rbc_vme_if_i.irq),
		.busy_drv_o(rbc_vme_if_i.busy_drv_o),
		.busy_drv_oe(rbc_vme_if_i.busy_drv_oe),
		.busy_ext(rbc_vme_if_i.busy_ext), .busy_line(rbc_vme_if_i.busy_line));

	// ----------------------------------------
	// Verdict and bus tasks
	// ----------------------------------------
	task automatic final_report;
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Lost handshake: count it and stop
	task automatic give_up;
		err_count++;
		final_report();
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
		end while (!s_bvalid && n < 50);
		s_bready <= 1'b0;
		if (n >= 50)
			give_up();
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_arready)
				s_arvalid <= 1'b0;
		end while (!s_rvalid && n < 50);
		rd_word = s_rdata;
		s_rready <= 1'b0;
		if (n >= 50)
			give_up();
	endtask
	// One board cycle through the host; waits until the host is idle
	task automatic bus(input logic w, input logic [7:0] off,
		input logic [15:0] d);
		int n;
		axi_wr(`RBC_H_ADDR, {8'h00, tgt, off});
		axi_wr(`RBC_H_WDATA, {16'h0000, d});
		axi_wr(`RBC_H_CTRL, {30'h0, w, 1'b1});
		n = 0;
		do
		begin
			axi_rd(`RBC_H_STAT);
			n++;
		end while (rd_word[0] && n < 40);
		if (n >= 40)
			give_up();
		if (!w)
			axi_rd(`RBC_H_RDATA);
	endtask
	// Busy output must reach v within a few synchroniser delays
	task automatic wait_busy(input int c, input logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end while (busy_out[c] !== v && n < 20);
		`CHK("busy wait", v, busy_out[c])
		if (busy_out[c] !== v)
			final_report();
	endtask
	// One slow clock period
	task automatic tick;
		@(posedge aclk);
		slow_clk <= 1'b1;
		repeat (4) @(posedge aclk);
		slow_clk <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		axi_wr(`RBC_H_CTRL, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, 8'(2 * i), 16'h0);
			`CHK("csr", 16'h00ff, rd_word[15:0])
		end
		`CHK("lamps", 12'hff0, led)
	endtask
	task automatic t_pulse;
		bus(1'b1, 8'h00, 16'h00ec);
		bus(1'b0, 8'h00, 16'h0);
		`CHK("csr0", 16'h00ec, rd_word[15:0])
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b1, 8'h50, 16'h0);
			`CHK("busy set", 1'b1, busy_out[0])
			bus(1'b1, 8'h58, 16'h0);
			`CHK("busy release", 1'b0, busy_out[0])
		end
		bus(1'b0, 8'h12, 16'h0);
		`CHK("pulse count", 16'h0003, rd_word[15:0])
		// Fast clear enabled: a low level empties the counter
		bus(1'b1, 8'h00, 16'h00ac);
		fast_clear_n <= 1'b0;
		repeat (4) @(posedge aclk);
		fast_clear_n <= 1'b1;
		bus(1'b0, 8'h12, 16'h0);
		`CHK("fast clear", 16'h0000, rd_word[15:0])
	endtask
	// Free mode on the panel and both differential sources, then latched mode on the panel pin
	task automatic t_modes;
		for (int c = 0; c < 3; c++)
		begin
			// Idle level of this source before the mode is set
			trig_diff[1] <= (c == 1);
			bus(1'b1, 8'h02, {8'h00, 4'he, c[1:0], 2'b10});
			`CHK("idle", 1'b0, busy_out[1])
			trig_panel_n[1] <= (c != 0);
			trig_diff[1] <= (c == 2);
			wait_busy(1, 1'b1);
			trig_panel_n[1] <= 1'b1;
			trig_diff[1] <= (c == 1);
			wait_busy(1, 1'b0);
		end
		bus(1'b1, 8'h02, 16'h00e0);
		trig_panel_n[1] <= 1'b0;
		wait_busy(1, 1'b1);
		trig_panel_n[1] <= 1'b1;
		repeat (6) @(posedge aclk);
		`CHK("latched", 1'b1, busy_out[1])
		bus(1'b1, 8'h5a, 16'h0);
		`CHK("released", 1'b0, busy_out[1])
	endtask
	// Output shows the wired-OR line, driven from outside or locally
	task automatic t_shared;
		bus(1'b1, 8'h04, 16'h00f0);
		rbc_vme_if_i.busy_ext[2] <= 1'b1;
		wait_busy(2, 1'b1);
		`CHK("local idle", 1'b0, rbc_vme_if_i.busy_drv_o[2])
		rbc_vme_if_i.busy_ext[2] <= 1'b0;
		wait_busy(2, 1'b0);
		bus(1'b1, 8'h54, 16'h0);
		wait_busy(2, 1'b1);
		bus(1'b1, 8'h5c, 16'h0);
		wait_busy(2, 1'b0);
	endtask
	// 10 ms offset: overflow comes on the hundredth tick
	task automatic t_timeout;
		bus(1'b1, 8'h06, 16'h00ec);
		bus(1'b1, 8'h42, 16'h0080);
		bus(1'b1, 8'h26, `RBC_DT_OFFSET_10MS);
		bus(1'b1, 8'h56, 16'h0);
		repeat (99) tick();
		bus(1'b0, 8'h40, 16'h0);
		`CHK("early flag", 16'h0000, rd_word[15:0] & 16'h0080)
		tick();
		bus(1'b0, 8'h40, 16'h0);
		`CHK("timeout flag", 16'h0080, rd_word[15:0] & 16'h0080)
		`CHK("board irq", 1'b1, rbc_vme_if_i.irq)
		bus(1'b1, 8'h40, 16'h0080);
		bus(1'b1, 8'h5e, 16'h0);
		`CHK("board irq off", 1'b0, rbc_vme_if_i.irq)
	endtask
	// Foreign base: no answer; host flag raised, masked and cleared
	task automatic t_refuse;
		axi_wr(`RBC_H_ISTAT, 32'h7);
		tgt = ~BASE;
		bus(1'b1, 8'h50, 16'h0);
		tgt = BASE;
		axi_rd(`RBC_H_ISTAT);
		`CHK("no answer", 32'h2, rd_word & 32'h2)
		`CHK("busy kept", 1'b0, busy_out[0])
		axi_wr(`RBC_H_IMASK, 32'h2);
		@(posedge aclk);
		`CHK("irq up", 1'b1, irq)
		axi_wr(`RBC_H_IMASK, 32'h0);
		@(posedge aclk);
		`CHK("irq masked", 1'b0, irq)
		axi_wr(`RBC_H_IMASK, 32'h2);
		axi_wr(`RBC_H_ISTAT, 32'h2);
		@(posedge aclk);
		`CHK("irq cleared", 1'b0, irq)
	endtask
	// Each switch pair shows its channel's control bits
	task automatic t_display;
		for (int i = 0; i < 4; i++)
		begin
			disp_top_left <= i[0];
			disp_bot_left <= i[1];
			repeat (6) @(posedge aclk);
			`CHK("lamps", exp_csr[i], led[11:4])
		end
	endtask
	// Mid-run system reset: every channel back to all-ones control
	task automatic t_sysres;
		axi_wr(`RBC_H_CTRL, 32'h4);
		repeat (2) @(posedge aclk);
		axi_wr(`RBC_H_CTRL, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, 8'(2 * i), 16'h0);
			`CHK("csr after reset", 16'h00ff, rd_word[15:0])
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		s_awaddr = 8'h00;
		s_araddr = 8'h00;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		trig_panel_n = 4'hf;
		trig_diff = 4'h0;
		fast_clear_n = 1'b1;
		slow_clk = 1'b0;
		disp_top_left = 1'b0;
		disp_bot_left = 1'b0;
		rbc_vme_if_i.busy_ext = 4'h0;
		tgt = BASE;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_pulse();
		t_modes();
		t_shared();
		t_timeout();
		t_refuse();
		t_display();
		t_sysres();
		final_report();
	end
endmodule
